// file: verilog/aes_event_status.sv
/*
  Event status, interrupt enables and operating mode of the accelerometer.
  Assumes the serial slave presents single-cycle register read and write
  strobes with an address, and holds xfer_busy high for a whole transfer.
  Tap and sample events arrive as one-cycle pulses on this clock.
*/
// Functional notes
// - Tap flag sets only if its enable set
// - Reading event flags clears and rearms them
// - Sample bit 7, reserved 6, taps 5..0
// - Sample flag always set, never suppressed
// - State field: 00 standby, 01 wake
// - Stall timeout resets slave, sets flag
// - Bit 7 shows fuse memory busy
// - Enables touch only the interrupt pin
// - Enabled tap drives pin; needs detect enable
// - Sample interrupt enable bit 7, default off
// - Control writable in standby and wake
// - Control field: 00 standby, 01 wake
// - Bit 4 enables low clock stall watchdog
// - Bit 5 enables high clock stall watchdog
// - Bit 6 selects push-pull, else open drain
// - Bit 7 selects active high, else low
// - No event flag set during a transfer
// - First-tap latch ignores taps until read
// - Master tap enable off disables all taps
`timescale 1ns/1ps
module aes_event_status #(
  parameter int STALL_LIMIT = aes_pkg::STALL_CYCLES
) (
  input wire logic clk, // 50 MHz sample clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [aes_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [aes_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic xfer_busy, // Serial transfer in progress
  input wire logic scl_pin, // Serial clock pin, async
  input wire logic fuse_busy_pin, // Fuse memory activity, async
  input wire logic sample_ready, // New sample pulse
  input wire logic [aes_pkg::TAPS-1:0] knock_detect, // Tap pulses
  output logic [aes_pkg::DATA_W-1:0] reg_rdata, // Read data
  output logic bus_stall_reset, // Slave to idle pulse
  output logic sampling_en, // Sampling active
  output logic accel_irq_pin_o, // Interrupt pin level
  output logic accel_irq_pin_oe // Interrupt pin drive enable
);
  import aes_pkg::*;

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] pend_reg;
  logic [7:0] pend_next;
  logic [7:0] irq_en_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] feat_reg;
  logic [7:0] knock_reg;
  logic stall_flag_reg;
  logic [STALL_CNT_W-1:0] stall_cnt_reg;
  logic [1:0] scl_sync_reg;
  logic scl_prev_reg;
  logic [1:0] fuse_sync_reg;
  logic [7:0] rdata_reg;
  logic stall_rst_reg;
  logic irq_o_reg;
  logic irq_oe_reg;
  aes_state_t state_reg;
  logic [7:0] taps_ok;
  logic [7:0] taps_take;
  logic rd_flags;
  logic rd_cond;
  logic stall_hit;
  logic stall_level;
  logic irq_active;
  logic [7:0] cond_byte;

  // Lowest set bit of a byte
  function automatic logic [7:0] lowest_bit(input logic [7:0] v);
    lowest_bit = v & (~v + 8'h01);
  endfunction

  function automatic logic is_addr(input logic [7:0] a,
                                   input logic [7:0] ofs);
    is_addr = (a == ofs);
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_sync_reg <= 2'b11;
      scl_prev_reg <= 1'b1;
      fuse_sync_reg <= 2'b00;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_pin};
      scl_prev_reg <= scl_sync_reg[1];
      fuse_sync_reg <= {fuse_sync_reg[0], fuse_busy_pin};
    end
  end

  assign rd_flags = reg_rd && is_addr(reg_addr, OFS_EVENT_FLAGS);
  assign rd_cond = reg_rd && is_addr(reg_addr, OFS_DEVICE_CONDITION);

  // Tap qualification and first-tap latch
  always_comb begin
    taps_ok = {2'b00, knock_detect} & knock_reg & TAP_MASK;
    if (!knock_reg[BIT_KNOCK_MASTER]) begin
      taps_ok = RST_BYTE;
    end
    taps_take = taps_ok;
    if (feat_reg[BIT_FIRST_TAP_LATCH]) begin
      if (((flags_reg | pend_reg) & TAP_MASK) != RST_BYTE) begin
        taps_take = RST_BYTE;
      end else begin
        taps_take = lowest_bit(taps_ok);
      end
    end
  end

  // Pending events gather while a transfer runs
  always_comb begin
    pend_next = pend_reg | taps_take;
    if (sample_ready) begin
      pend_next[BIT_SAMPLE_READY] = 1'b1;
    end
    flags_next = flags_reg;
    if (rd_flags) begin
      flags_next = RST_BYTE;
    end
    if (!xfer_busy) begin
      flags_next = (flags_next | pend_next) & EVENT_MASK;
      pend_next = RST_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_reg <= RST_BYTE;
      pend_reg <= RST_BYTE;
    end else begin
      flags_reg <= flags_next;
      pend_reg <= pend_next;
    end
  end

  // Register writes, accepted in either state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_en_reg <= RST_BYTE;
      ctrl_reg <= RST_BYTE;
      feat_reg <= RST_BYTE;
      knock_reg <= RST_BYTE;
    end else if (reg_wr) begin
      if (is_addr(reg_addr, OFS_INTERRUPT_ENABLES)) begin
        irq_en_reg <= reg_wdata & EVENT_MASK;
      end
      if (is_addr(reg_addr, OFS_OPERATING_CONTROL)) begin
        ctrl_reg <= reg_wdata & CTRL_WMASK;
      end
      if (is_addr(reg_addr, OFS_RATE_TAP_FEATURE)) begin
        feat_reg <= reg_wdata;
      end
      if (is_addr(reg_addr, OFS_KNOCK_CONTROL)) begin
        knock_reg <= reg_wdata;
      end
    end
  end

  // Operating state follows the control field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= AES_STANDBY;
      sampling_en <= 1'b0;
    end else begin
      unique case (ctrl_reg[1:0])
        STATE_WAKE: begin
          state_reg <= AES_WAKE;
          sampling_en <= 1'b1;
        end
        default: begin
          state_reg <= AES_STANDBY;
          sampling_en <= 1'b0;
        end
      endcase
    end
  end

  // Serial clock stall watchdog
  always_comb begin
    stall_level = 1'b0;
    if (scl_sync_reg[1]) begin
      stall_level = ctrl_reg[BIT_HIGH_STALL_EN];
    end else begin
      stall_level = ctrl_reg[BIT_LOW_STALL_EN];
    end
  end

  assign stall_hit = xfer_busy && stall_level &&
    (stall_cnt_reg == STALL_CNT_W'(STALL_LIMIT - 1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stall_cnt_reg <= '0;
      stall_rst_reg <= 1'b0;
      stall_flag_reg <= 1'b0;
    end else begin
      stall_rst_reg <= stall_hit;
      if (!xfer_busy || !stall_level || stall_hit ||
          (scl_sync_reg[1] != scl_prev_reg)) begin
        stall_cnt_reg <= '0;
      end else begin
        stall_cnt_reg <= stall_cnt_reg + 1'b1;
      end
      if (stall_hit) begin
        stall_flag_reg <= 1'b1;
      end else if (rd_cond) begin
        stall_flag_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    cond_byte = RST_BYTE;
    cond_byte[BIT_FUSE_BUSY] = fuse_sync_reg[1];
    cond_byte[BIT_STALL_FLAG] = stall_flag_reg;
    cond_byte[1:0] = (state_reg == AES_WAKE) ? STATE_WAKE
                                             : STATE_STANDBY;
  end

  // Read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_EVENT_FLAGS: rdata_reg <= flags_reg;
        OFS_DEVICE_CONDITION: rdata_reg <= cond_byte;
        OFS_INTERRUPT_ENABLES: rdata_reg <= irq_en_reg;
        OFS_OPERATING_CONTROL: rdata_reg <= ctrl_reg;
        OFS_RATE_TAP_FEATURE: rdata_reg <= feat_reg;
        OFS_KNOCK_CONTROL: rdata_reg <= knock_reg;
        default: rdata_reg <= RST_BYTE;
      endcase
    end
  end

  // Interrupt pin, enables gate only the pin
  assign irq_active = (flags_reg & irq_en_reg) != RST_BYTE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_o_reg <= 1'b0;
      irq_oe_reg <= 1'b0;
    end else if (ctrl_reg[BIT_PUSH_PULL]) begin
      irq_o_reg <= irq_active ~^ ctrl_reg[BIT_ACTIVE_HIGH];
      irq_oe_reg <= 1'b1;
    end else begin
      irq_o_reg <= 1'b0;
      irq_oe_reg <= irq_active ~^ !ctrl_reg[BIT_ACTIVE_HIGH];
    end
  end

  assign reg_rdata = rdata_reg;
  assign bus_stall_reset = stall_rst_reg;
  assign accel_irq_pin_o = irq_o_reg;
  assign accel_irq_pin_oe = irq_oe_reg;

  property p_tap_gate;
    @(posedge clk) disable iff (sys_rst)
      !knock_reg[BIT_KNOCK_MASTER] |=>
        ((pend_reg & ~$past(pend_reg) & TAP_MASK) == RST_BYTE);
  endproperty
  a_tap_gate: assert property (p_tap_gate)
    else $error("tap latched while taps disabled");

  property p_read_clear;
    @(posedge clk) disable iff (sys_rst)
      rd_flags && xfer_busy |=> flags_reg == RST_BYTE;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("event read did not clear flags");

  property p_sample_always;
    @(posedge clk) disable iff (sys_rst)
      sample_ready && !rd_flags |=>
        (pend_reg[BIT_SAMPLE_READY] || flags_reg[BIT_SAMPLE_READY]);
  endproperty
  a_sample_always: assert property (p_sample_always)
    else $error("sample event lost");

  property p_defer;
    @(posedge clk) disable iff (sys_rst)
      xfer_busy && !rd_flags |=> flags_reg == $past(flags_reg);
  endproperty
  a_defer: assert property (p_defer)
    else $error("flags changed during transfer");

  property p_state;
    @(posedge clk) disable iff (sys_rst)
      ctrl_reg[1:0] == STATE_WAKE |=> sampling_en ##1 sampling_en
        or ctrl_reg[1:0] != STATE_WAKE;
  endproperty
  a_state: assert property (p_state)
    else $error("state does not follow control");

  property p_stall;
    @(posedge clk) disable iff (sys_rst)
      stall_hit |=> bus_stall_reset && stall_flag_reg ##1 !bus_stall_reset;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall timeout not reported");

  property p_irq_hold;
    @(posedge clk) disable iff (sys_rst)
      irq_active && ctrl_reg[BIT_PUSH_PULL] && $stable(ctrl_reg) |=>
        accel_irq_pin_oe &&
        accel_irq_pin_o == $past(ctrl_reg[BIT_ACTIVE_HIGH]);
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt pin not asserted");

  property p_open_drain;
    @(posedge clk) disable iff (sys_rst)
      !ctrl_reg[BIT_PUSH_PULL] |=> !accel_irq_pin_o;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin driven high");

  property p_first_tap;
    @(posedge clk) disable iff (sys_rst)
      feat_reg[BIT_FIRST_TAP_LATCH] && !rd_flags &&
      ((flags_reg & TAP_MASK) != RST_BYTE) |=>
        (flags_reg & TAP_MASK) == ($past(flags_reg) & TAP_MASK);
  endproperty
  a_first_tap: assert property (p_first_tap)
    else $error("later tap latched in first-tap mode");

  property p_fuse;
    @(posedge clk) disable iff (sys_rst)
      rd_cond |=> reg_rdata[BIT_FUSE_BUSY] == $past(fuse_sync_reg[1]);
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("fuse busy bit not reported");
endmodule

// file: verilog/aes_pkg.sv
/*
  Constants for the accelerometer event status and mode block:
  register offsets, field positions, reset values and timing.
  Assumes an 8-bit register address and data path from the serial slave.
*/
package aes_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int TAPS = 6;

  // Register offsets
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h03;
  localparam logic [7:0] OFS_DEVICE_CONDITION = 8'h04;
  localparam logic [7:0] OFS_INTERRUPT_ENABLES = 8'h06;
  localparam logic [7:0] OFS_OPERATING_CONTROL = 8'h07;
  localparam logic [7:0] OFS_RATE_TAP_FEATURE = 8'h08;
  localparam logic [7:0] OFS_KNOCK_CONTROL = 8'h09;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Event flag layout
  localparam int BIT_SAMPLE_READY = 7;
  localparam logic [7:0] TAP_MASK = 8'h3F;
  localparam logic [7:0] EVENT_MASK = 8'hBF;

  // Device condition layout
  localparam int BIT_FUSE_BUSY = 7;
  localparam int BIT_STALL_FLAG = 4;
  localparam logic [1:0] STATE_STANDBY = 2'h0;
  localparam logic [1:0] STATE_WAKE = 2'h1;

  // Operating control layout
  localparam int BIT_LOW_STALL_EN = 4;
  localparam int BIT_HIGH_STALL_EN = 5;
  localparam int BIT_PUSH_PULL = 6;
  localparam int BIT_ACTIVE_HIGH = 7;
  localparam logic [7:0] CTRL_WMASK = 8'hF3;

  // Rate/tap feature and knock control layout
  localparam int BIT_FIRST_TAP_LATCH = 7;
  localparam int BIT_KNOCK_MASTER = 7;

  // Clock and stall timeout
  localparam int CLK_HZ = 50_000_000;
  localparam int STALL_TIMEOUT_US = 25_000;
  localparam int STALL_CYCLES = STALL_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int STALL_CNT_W = 24;

  typedef enum logic [1:0] {
    AES_STANDBY = 2'b01,
    AES_WAKE = 2'b10
  } aes_state_t;
endpackage

// file: sim/aes_host_model.sv
/*
  Host model: register master, serial line levels, pin pull-up.
  Assumes strobes are sampled on the rising clock edge.
*/
`timescale 1ns/1ps
module aes_host_model (
  input wire logic clk, // Clock
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic pin_o, // Pin value
  input wire logic pin_oe, // Pin drive enable
  output logic [7:0] reg_addr, // Address
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [7:0] reg_wdata, // Write data
  output logic xfer_busy, // Transfer flag
  output logic scl_pin, // Serial clock level
  output wire logic pin_level // Resolved pin
);
  import aes_pkg::*;
  // Pull-up when released
  assign pin_level = pin_oe ? pin_o : 1'b1;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    xfer_busy = 1'b0;
    scl_pin = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    // Bit 2 of control kept zero
    reg_wdata <= (a == OFS_OPERATING_CONTROL) ? d & 8'hFB : d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic line(input logic b, input logic s);
    @(posedge clk);
    xfer_busy <= b;
    scl_pin <= s;
  endtask
endmodule

// file: sim/aes_event_status_tb_top.sv
/*
  Self-checking bench of the event status block.
  Assumes the host model drives the register port and serial lines.
*/
`timescale 1ns/1ps
module aes_event_status_tb_top;
  import aes_pkg::*;
  localparam int LIM = 16;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } aes_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fuse_busy_pin = 1'b0;
  logic sample_ready = 1'b0;
  logic [5:0] knock_detect = 6'h00;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, xfer_busy, scl_pin;
  logic stall, samp_en, pin_o, pin_oe, pin_lvl;
  int failures = 0;
  int samples_checked = 0;
  aes_row_t rows [7] = '{'{8'h06, 8'hFF, 8'hBF}, '{8'h07, 8'hFF, 8'hF3},
    '{8'h08, 8'h0F, 8'h0F}, '{8'h09, 8'hBF, 8'hBF}, '{8'h05, 8'hFF, 8'h00},
    '{8'h04, 8'hFF, 8'h00}, '{8'h03, 8'hFF, 8'h00}};

  always #10 clk = ~clk;

  aes_event_status #(.STALL_LIMIT(LIM)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .xfer_busy(xfer_busy), .scl_pin(scl_pin),
    .fuse_busy_pin(fuse_busy_pin), .sample_ready(sample_ready),
    .knock_detect(knock_detect), .reg_rdata(reg_rdata),
    .bus_stall_reset(stall), .sampling_en(samp_en),
    .accel_irq_pin_o(pin_o), .accel_irq_pin_oe(pin_oe));

  aes_host_model u_host (.clk(clk), .reg_rdata(reg_rdata), .pin_o(pin_o),
    .pin_oe(pin_oe), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .xfer_busy(xfer_busy), .scl_pin(scl_pin),
    .pin_level(pin_lvl));

  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk(d, e);
  endtask

  task automatic pulse(input logic [5:0] k, input logic s);
    @(posedge clk);
    knock_detect <= k;
    sample_ready <= s;
    @(posedge clk);
    knock_detect <= 6'h00;
    sample_ready <= 1'b0;
  endtask

  task automatic stall_wait();
    int n;
    n = 0;
    while (stall !== 1'b1 && n < 4 * LIM) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, stall}, 8'h01);
  endtask

  task automatic pin_chk(input logic [7:0] e);
    repeat (2) @(negedge clk);
    chk({5'h00, pin_oe, pin_o, pin_lvl}, e);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({6'h00, pin_oe, samp_en}, 8'h00);
    rdchk(OFS_EVENT_FLAGS, RST_BYTE);
    rdchk(OFS_DEVICE_CONDITION, RST_BYTE);
    rdchk(OFS_INTERRUPT_ENABLES, RST_BYTE);
    rdchk(OFS_OPERATING_CONTROL, RST_BYTE);
    foreach (rows[i]) begin
      u_host.wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e);
    end
    u_host.wr(OFS_OPERATING_CONTROL, 8'h00);
    u_host.wr(OFS_INTERRUPT_ENABLES, 8'h00);
    u_host.wr(OFS_KNOCK_CONTROL, 8'h3F);
    pulse(6'h3F, 1'b0);
    rdchk(OFS_EVENT_FLAGS, 8'h00);
    u_host.wr(OFS_KNOCK_CONTROL, 8'h85);
    pulse(6'h3F, 1'b1);
    rdchk(OFS_EVENT_FLAGS, 8'h85);
    rdchk(OFS_EVENT_FLAGS, 8'h00);
    // Open drain, active low, sample interrupt
    u_host.wr(OFS_INTERRUPT_ENABLES, 8'h81);
    pulse(6'h00, 1'b1);
    pin_chk(8'h04);
    rdchk(OFS_EVENT_FLAGS, 8'h80);
    pin_chk(8'h01);
    // Push-pull, active high, wake
    u_host.wr(OFS_OPERATING_CONTROL, 8'hC1);
    rdchk(OFS_DEVICE_CONDITION, 8'h01);
    chk({7'h00, samp_en}, 8'h01);
    pulse(6'h01, 1'b0);
    pin_chk(8'h07);
    rdchk(OFS_EVENT_FLAGS, 8'h01);
    pin_chk(8'h04);
    // Open drain, active high
    u_host.wr(OFS_OPERATING_CONTROL, 8'h80);
    pin_chk(8'h04);
    pulse(6'h00, 1'b1);
    pin_chk(8'h01);
    rdchk(OFS_EVENT_FLAGS, 8'h80);
    u_host.wr(OFS_RATE_TAP_FEATURE, 8'h80);
    pulse(6'h04, 1'b0);
    pulse(6'h01, 1'b0);
    rdchk(OFS_EVENT_FLAGS, 8'h04);
    // Events held back during a transfer
    u_host.line(1'b1, 1'b1);
    pulse(6'h00, 1'b1);
    rdchk(OFS_EVENT_FLAGS, 8'h00);
    u_host.line(1'b0, 1'b1);
    rdchk(OFS_EVENT_FLAGS, 8'h80);
    u_host.wr(OFS_OPERATING_CONTROL, 8'h10);
    u_host.line(1'b1, 1'b0);
    stall_wait();
    u_host.line(1'b0, 1'b1);
    rdchk(OFS_DEVICE_CONDITION, 8'h10);
    rdchk(OFS_DEVICE_CONDITION, 8'h00);
    u_host.wr(OFS_OPERATING_CONTROL, 8'h20);
    u_host.line(1'b1, 1'b1);
    stall_wait();
    u_host.line(1'b0, 1'b1);
    fuse_busy_pin <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk(OFS_DEVICE_CONDITION, 8'h90);
    // Second reset in mid-run
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({6'h00, pin_oe, samp_en}, 8'h00);
    rdchk(OFS_INTERRUPT_ENABLES, RST_BYTE);
    rdchk(OFS_OPERATING_CONTROL, RST_BYTE);
    tally_and_finish();
  end
endmodule
